// ==== rtl/pll_holdover_controller.v ====
// holdover control, digital lock detect, lock pin, reference monitors and registers
// Operation
// - holdover puts the charge pump in high impedance, never constant pumping.
// - both holdover enable bits must be set; otherwise no holdover of any kind.
// - manual mode enters high impedance on a falling edge of the align pin.
// - manual exit waits for pin high and next reference-path detector edge.
// - feedback B counter resets on that same release edge; prescaler untouched.
// - automatic mode enters high impedance when the sensed lock level is low.
// - comparator enable cleared makes the lock pin read as high; the status pin comparator route still passes the raw pin level.
// - automatic holdover persists while no reference edge arrives.
// - re-entry waits for relock, and pin charge when comparator is on.
// - holdover follows the selected reference; in automatic mode switchover holds until next edge.
// - two-bit counter code sets consecutive in-window cycles; 00 means five.
// - lock detect disable bit must be zero; automatic holdover needs it.
// - pin select code 000100 gives current-source lock detect mode.
// - external control bit zero selects automatic, one selects pin-driven holdover.
// - lock window bit zero selects the high range thresholds.
// - three monitors flag slow references and VCO, or clock input as feedback.
// - reference monitors have normal/extended thresholds; three status bits.
// - pin select 0xF7 routes primary reference status, active low, out.
// - reference buffer field 11 enables both reference input buffers.
// - lock stays flagged until one cycle exceeds the unlock threshold.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "pll_holdover_map.vh"

module pll_holdover_controller #(
   parameter PW = 8,
   parameter LOCK_THR_HI = 8'h20,
   parameter UNLOCK_THR_HI = 8'h40,
   parameter LOCK_THR_LO = 8'h08,
   parameter UNLOCK_THR_LO = 8'h10,
   parameter [7:0] LOCK_CNT1 = 8'h10,
   parameter [7:0] LOCK_CNT2 = 8'h40,
   parameter [7:0] LOCK_CNT3 = 8'hFF,
   parameter MW = 12,
   parameter [11:0] REF_THR_NORM = 12'h100,
   parameter [11:0] REF_THR_EXT = 12'h800,
   parameter [11:0] VCO_THR = 12'h040
) (
   // clock and reset
   input wire clk_sys,
   input wire reset,
   // register port
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_ff,
   // phase detector events
   input wire pfd_ref_edge,
   input wire pfd_cycle,
   input wire [PW-1:0] pfd_phase_diff,
   // align request pin, active low
   input wire align_req_n,
   // lock indicator pin
   input wire lock_indicator_pin_level,
   output reg lock_pin_out_ff,
   output reg lock_pin_oe_ff,
   output reg lock_pin_src_on_ff,
   // monitor ticks
   input wire primary_ref_tick,
   input wire secondary_ref_tick,
   input wire vco_tick,
   input wire clk_in_tick,
   // loop controls
   output reg charge_pump_hiz_ff,
   output reg b_counter_reset_ff,
   output reg digital_lock_flag_ff,
   output reg reference_monitor_pin_ff,
   output reg ref_select_ff,
   output reg [1:0] ref_buf_en_ff
);

   localparam ST_IDLE = 2'd0;
   localparam ST_HOLD = 2'd1;
   localparam ST_REARM = 2'd2;

   // lock count for each code of the two-bit field
   function [7:0] lock_target;
      input [1:0] code;
      begin
         case (code)
            2'd0: lock_target = `LOCK_CNT_CODE0;
            2'd1: lock_target = LOCK_CNT1;
            2'd2: lock_target = LOCK_CNT2;
            default: lock_target = LOCK_CNT3;
         endcase
      end
   endfunction

   // a monitor is slow once its count has reached the threshold
   function slow_flag;
      input [MW-1:0] cnt;
      input [MW-1:0] thr;
      begin
         slow_flag = cnt >= thr;
      end
   endfunction

   // cycles since last tick, saturating
   function [MW-1:0] mon_count;
      input tick;
      input [MW-1:0] cnt;
      begin
         if (tick) begin
            mon_count = {MW{1'b0}};
         end else if (&cnt) begin
            mon_count = cnt;
         end else begin
            mon_count = cnt + 1'b1;
         end
      end
   endfunction

   reg [7:0] lock_det_ff;
   reg [7:0] ld_sel_ff;
   reg [7:0] reference_monitor_pin_sel_ff;
   reg [7:0] ref_ctrl_ff;
   reg [7:0] holdover_ff;
   reg [7:0] lock_cnt_ff;
   reg [7:0] nxt_lock_cnt;
   reg nxt_dld;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg nxt_hiz;
   reg nxt_brst;
   reg align_prev_ff;
   reg ref_sel_prev_ff;
   reg [MW-1:0] primary_reference_cnt_ff;
   reg [MW-1:0] secondary_reference_cnt_ff;
   reg [MW-1:0] vco_cnt_ff;
   reg primary_reference_slow_ff;
   reg secondary_reference_slow_ff;
   reg vco_slow_ff;
   reg [7:0] nxt_rdata;
   reg nxt_reference_monitor_pin;
   reg nxt_pin_src;
   reg nxt_pin_oe;
   reg nxt_pin_out;

   wire ho_enabled;
   wire ext_mode;
   wire dld_disabled;
   wire high_range;
   wire [PW-1:0] lock_thr;
   wire [PW-1:0] unlock_thr;
   wire lock_sensed;
   wire align_fall;
   wire switchover;
   wire auto_trig;
   wire [MW-1:0] ref_thr;
   wire fb_tick;
   wire [7:0] status_word;

   assign ho_enabled = holdover_ff[`HO_EN_A_BIT] & holdover_ff[`HO_EN_B_BIT];
   assign ext_mode = holdover_ff[`HO_EXT_BIT];
   assign dld_disabled = lock_det_ff[`DLD_DIS_BIT];
   assign high_range = ~lock_det_ff[`LOCK_WIN_BIT];
   assign lock_thr = high_range ? LOCK_THR_HI : LOCK_THR_LO;
   assign unlock_thr = high_range ? UNLOCK_THR_HI : UNLOCK_THR_LO;
   // a disabled comparator reads the pin as locked
   assign lock_sensed = ~holdover_ff[`LDCMP_EN_BIT] | lock_indicator_pin_level;
   assign align_fall = align_prev_ff & ~align_req_n;
   // a new selection has no valid detector edge until the new reference arrives
   assign switchover = ref_sel_prev_ff != ref_ctrl_ff[`REF_SEL_BIT];
   // automatic holdover only runs with the digital lock detector on
   assign auto_trig = ~ext_mode & ~dld_disabled & (~lock_sensed | switchover);
   // the extended threshold bit sits in the lock pin select register
   assign ref_thr = ld_sel_ff[`REF_EXT_THR_BIT] ? REF_THR_EXT : REF_THR_NORM;
   assign fb_tick = ref_ctrl_ff[`FB_CLK_IN_BIT] ? clk_in_tick : vco_tick;

   // read-only status word
   assign status_word = {
      2'b00,
      lock_sensed,
      charge_pump_hiz_ff,
      vco_slow_ff,
      secondary_reference_slow_ff,
      primary_reference_slow_ff,
      digital_lock_flag_ff
   };

   // register writes
   always @(posedge clk_sys) begin
      if (reset) begin
         lock_det_ff <= `RST_REG8;
         ld_sel_ff <= `RST_REG8;
         reference_monitor_pin_sel_ff <= `RST_REG8;
         ref_ctrl_ff <= `RST_REG8;
         holdover_ff <= `RST_REG8;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_LOCK_DET: lock_det_ff <= reg_wdata;
            `REG_LD_PIN_SEL: ld_sel_ff <= reg_wdata;
            `REG_REFERENCE_MONITOR_PIN_SEL: reference_monitor_pin_sel_ff <= reg_wdata;
            `REG_REF_CTRL: ref_ctrl_ff <= reg_wdata;
            `REG_HOLDOVER: holdover_ff <= {4'h0, reg_wdata[3:0]};
            default: ;
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always @* begin
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `REG_LOCK_DET: nxt_rdata = lock_det_ff;
            `REG_LD_PIN_SEL: nxt_rdata = ld_sel_ff;
            `REG_REFERENCE_MONITOR_PIN_SEL: nxt_rdata = reference_monitor_pin_sel_ff;
            `REG_REF_CTRL: nxt_rdata = ref_ctrl_ff;
            `REG_HOLDOVER: nxt_rdata = holdover_ff;
            `REG_STATUS: nxt_rdata = status_word;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // digital lock detect with hysteresis between lock and unlock windows
   always @* begin
      nxt_lock_cnt = lock_cnt_ff;
      nxt_dld = digital_lock_flag_ff;
      if (dld_disabled) begin
         nxt_lock_cnt = 8'h00;
         nxt_dld = 1'b0;
      end else if (pfd_cycle) begin
         if (digital_lock_flag_ff) begin
            if (pfd_phase_diff > unlock_thr) begin
               nxt_dld = 1'b0;
               nxt_lock_cnt = 8'h00;
            end
         end else if (pfd_phase_diff < lock_thr) begin
            nxt_lock_cnt = lock_cnt_ff + 8'h01;
            if (nxt_lock_cnt >= lock_target(lock_det_ff[`LOCK_CNT_MSB:`LOCK_CNT_LSB])) begin
               nxt_dld = 1'b1;
            end
         end else begin
            nxt_lock_cnt = 8'h00;
         end
      end
   end

   // holdover sequencing; high impedance replaces any pump drive
   always @* begin
      nxt_state = state_ff;
      nxt_hiz = charge_pump_hiz_ff;
      nxt_brst = 1'b0;
      if (!ho_enabled) begin
         nxt_state = ST_IDLE;
         nxt_hiz = 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (ext_mode ? align_fall : auto_trig) begin
                  nxt_state = ST_HOLD;
                  nxt_hiz = 1'b1;
               end
            end
            ST_HOLD: begin
               // no reference edge means no release
               if (pfd_ref_edge && (!ext_mode || align_req_n)) begin
                  nxt_state = ext_mode ? ST_IDLE : ST_REARM;
                  nxt_hiz = 1'b0;
                  nxt_brst = 1'b1;
               end
            end
            // holding off re-entry keeps lock chatter from retriggering holdover
            ST_REARM: begin
               if (ext_mode || (digital_lock_flag_ff && lock_sensed)) begin
                  nxt_state = ST_IDLE;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_hiz = 1'b0;
            end
         endcase
      end
   end

   // status pin routing
   always @* begin
      case (reference_monitor_pin_sel_ff)
         `REFERENCE_MONITOR_PIN_PRIMARY_REFERENCE_N: nxt_reference_monitor_pin = primary_reference_slow_ff;
         `REFERENCE_MONITOR_PIN_DLD: nxt_reference_monitor_pin = digital_lock_flag_ff;
         `REFERENCE_MONITOR_PIN_LDCMP: nxt_reference_monitor_pin = lock_indicator_pin_level;
         default: nxt_reference_monitor_pin = 1'b0;
      endcase
   end

   // lock pin drive; any code other than the two known ones releases the pin
   always @* begin
      nxt_pin_src = 1'b0;
      nxt_pin_oe = 1'b0;
      nxt_pin_out = 1'b0;
      case (ld_sel_ff[`LD_SEL_MSB:`LD_SEL_LSB])
         `LD_SEL_CUR_SRC: begin
            // current source charges the capacitor while locked, shorts it otherwise
            nxt_pin_src = nxt_dld;
            nxt_pin_oe = ~nxt_dld;
         end
         `LD_SEL_DLD: begin
            nxt_pin_oe = 1'b1;
            nxt_pin_out = nxt_dld;
         end
         default: begin
            nxt_pin_src = 1'b0;
         end
      endcase
   end

   // register read answer and lock detect state
   always @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata_ff <= 8'h00;
         lock_cnt_ff <= 8'h00;
         digital_lock_flag_ff <= 1'b0;
      end else begin
         reg_rdata_ff <= nxt_rdata;
         lock_cnt_ff <= nxt_lock_cnt;
         digital_lock_flag_ff <= nxt_dld;
      end
   end

   // holdover state; the align history resets high so leaving reset with the pin high is no edge
   always @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         charge_pump_hiz_ff <= 1'b0;
         b_counter_reset_ff <= 1'b0;
         align_prev_ff <= 1'b1;
         ref_sel_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         charge_pump_hiz_ff <= nxt_hiz;
         b_counter_reset_ff <= nxt_brst;
         align_prev_ff <= align_req_n;
         ref_sel_prev_ff <= ref_ctrl_ff[`REF_SEL_BIT];
      end
   end

   // frequency monitors; a slow flag trails its count by one cycle
   always @(posedge clk_sys) begin
      if (reset) begin
         primary_reference_cnt_ff <= {MW{1'b0}};
         secondary_reference_cnt_ff <= {MW{1'b0}};
         vco_cnt_ff <= {MW{1'b0}};
         primary_reference_slow_ff <= 1'b0;
         secondary_reference_slow_ff <= 1'b0;
         vco_slow_ff <= 1'b0;
      end else begin
         primary_reference_cnt_ff <= mon_count(primary_ref_tick, primary_reference_cnt_ff);
         secondary_reference_cnt_ff <= mon_count(secondary_ref_tick, secondary_reference_cnt_ff);
         vco_cnt_ff <= mon_count(fb_tick, vco_cnt_ff);
         primary_reference_slow_ff <= slow_flag(primary_reference_cnt_ff, ref_thr);
         secondary_reference_slow_ff <= slow_flag(secondary_reference_cnt_ff, ref_thr);
         vco_slow_ff <= slow_flag(vco_cnt_ff, VCO_THR);
      end
   end

   // pin and reference outputs
   always @(posedge clk_sys) begin
      if (reset) begin
         lock_pin_out_ff <= 1'b0;
         lock_pin_oe_ff <= 1'b0;
         lock_pin_src_on_ff <= 1'b0;
         reference_monitor_pin_ff <= 1'b0;
         ref_select_ff <= 1'b0;
         ref_buf_en_ff <= 2'b00;
      end else begin
         lock_pin_out_ff <= nxt_pin_out;
         lock_pin_oe_ff <= nxt_pin_oe;
         lock_pin_src_on_ff <= nxt_pin_src;
         reference_monitor_pin_ff <= nxt_reference_monitor_pin;
         ref_select_ff <= ref_ctrl_ff[`REF_SEL_BIT];
         ref_buf_en_ff <= ref_ctrl_ff[`REF_BUF_MSB:`REF_BUF_LSB];
      end
   end

endmodule

// ==== rtl/pll_holdover_map.vh ====
// register offsets, field positions and reset values of the holdover controller
`ifndef PLL_HOLDOVER_MAP_VH
`define PLL_HOLDOVER_MAP_VH

`define ADDR_W 10
`define REG_LOCK_DET 10'h018
`define REG_LD_PIN_SEL 10'h01A
`define REG_REFERENCE_MONITOR_PIN_SEL 10'h01B
`define REG_REF_CTRL 10'h01C
`define REG_HOLDOVER 10'h01D
`define REG_STATUS 10'h01F

`define LOCK_CNT_MSB 6
`define LOCK_CNT_LSB 5
`define LOCK_WIN_BIT 4
`define DLD_DIS_BIT 3

`define LD_SEL_MSB 5
`define LD_SEL_LSB 0
`define REF_EXT_THR_BIT 6
`define LD_SEL_CUR_SRC 6'h04
`define LD_SEL_DLD 6'h01

`define REFERENCE_MONITOR_PIN_PRIMARY_REFERENCE_N 8'hF7
`define REFERENCE_MONITOR_PIN_DLD 8'h01
`define REFERENCE_MONITOR_PIN_LDCMP 8'h02

`define REF_SEL_BIT 0
`define REF_BUF_MSB 2
`define REF_BUF_LSB 1
`define FB_CLK_IN_BIT 3

`define HO_EN_A_BIT 0
`define HO_EXT_BIT 1
`define HO_EN_B_BIT 2
`define LDCMP_EN_BIT 3

`define LOCK_CNT_CODE0 8'h05
`define RST_REG8 8'h00

`endif

// ==== test/pll_far_side.sv ====
// reference clock source and lock pin capacitor facing the controller
module pll_far_side #(
   parameter int REF_PER = 8,
   parameter int CHG = 12
) (
   // clock and bench control
   input wire logic clk_sys,
   input wire logic ref_on,
   // lock pin current source
   input wire logic src_on,
   // toward the controller
   output logic pfd_ref_edge,
   output logic pfd_cycle,
   output logic lock_level
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int chg = 0;
   logic edge_q = 1'h0;
   always @(posedge clk_sys) begin
      cnt <= (cnt == REF_PER - 1) ? 0 : cnt + 1;
      // a lost reference simply gives no detector edges at all
      edge_q <= ref_on && cnt == 0;
      // capacitor charges slowly, but is shorted at once when the source drops
      chg <= src_on ? (chg < CHG ? chg + 1 : chg) : 0;
   end
   assign pfd_ref_edge = edge_q;
   assign pfd_cycle = edge_q;
   assign lock_level = chg >= CHG;
endmodule

// ==== test/pll_holdover_controller_chk.sv ====
// port-level assertion checker for the holdover controller
`include "pll_holdover_map.vh"
module pll_holdover_controller_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   // loop signals
   input wire logic pfd_ref_edge,
   input wire logic pfd_cycle,
   input wire logic align_req_n,
   input wire logic charge_pump_hiz_ff,
   input wire logic b_counter_reset_ff,
   input wire logic digital_lock_flag_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ho_ff;
   logic en;
   // shadow of the holdover control bits, which never reach the ports
   always_ff @(posedge clk_sys) begin
      if (reset)
         ho_ff <= 4'h0;
      else if (reg_wr && reg_addr == `REG_HOLDOVER)
         ho_ff <= reg_wdata[3:0];
   end
   assign en = ho_ff[0] && ho_ff[2];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_release_pulse: assert property ($fell(charge_pump_hiz_ff) |-> b_counter_reset_ff)
      else $error("b counter reset missing at release");
   chk_pulse_short: assert property (b_counter_reset_ff |=> !b_counter_reset_ff)
      else $error("b counter reset longer than one cycle");
   chk_release_edge: assert property ($fell(charge_pump_hiz_ff) |-> $past(pfd_ref_edge))
      else $error("release without reference edge");
   chk_manual_entry: assert property (en && ho_ff[1] && $fell(align_req_n) |=> charge_pump_hiz_ff)
      else $error("no high impedance after align fall");
   chk_off_no_hiz: assert property (!en |=> !charge_pump_hiz_ff)
      else $error("high impedance while holdover disabled");
   chk_hold_no_ref: assert property (en && charge_pump_hiz_ff && !pfd_ref_edge |=> charge_pump_hiz_ff)
      else $error("release without reference edge");
   chk_lock_cause: assert property ($rose(digital_lock_flag_ff) |-> $past(pfd_cycle) || $past(pfd_cycle, 2))
      else $error("lock flag rose without detector cycle");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
      else $error("read data outside read answer cycle");
   cover property ($rose(charge_pump_hiz_ff));
   cover property (b_counter_reset_ff);
   cover property ($fell(digital_lock_flag_ff));
endmodule

// ==== test/pll_holdover_controller_tb.sv ====
// self-checking bench for the holdover controller
`include "pll_holdover_map.vh"
module pll_holdover_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic [9:0] addr = 10'h000;
   logic [7:0] wd = 8'h00;
   logic wr_s = 1'h0;
   logic rd_s = 1'h0;
   logic [7:0] diff = 8'h50;
   logic align_n = 1'h1;
   logic ref_on = 1'h1;
   logic tick_en = 1'h0;
   logic tk = 1'h0;
   logic [7:0] rdata, v;
   logic [1:0] rbuf;
   logic hiz, brst, dlf, reference_monitor_pin, src_on, pfd_e, pfd_c, lvl;
   logic rsel, poe;
   int err_total = 0;
   int n_checks = 0;
   int nb = 0;
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) tk <= tick_en && !tk;
   always @(posedge clk_sys) if (brst === 1'h1) nb++;
   pll_holdover_controller i_pll_holdover_controller (
      .clk_sys(clk_sys), .reset(reset), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata_ff(rdata), .pfd_ref_edge(pfd_e), .pfd_cycle(pfd_c),
      .pfd_phase_diff(diff), .align_req_n(align_n), .lock_indicator_pin_level(lvl),
      .lock_pin_out_ff(), .lock_pin_oe_ff(poe), .lock_pin_src_on_ff(src_on),
      .primary_ref_tick(tk), .secondary_ref_tick(tk), .vco_tick(tk), .clk_in_tick(tk),
      .charge_pump_hiz_ff(hiz), .b_counter_reset_ff(brst), .digital_lock_flag_ff(dlf),
      .reference_monitor_pin_ff(reference_monitor_pin), .ref_select_ff(rsel), .ref_buf_en_ff(rbuf));
   pll_far_side i_pll_far_side (.clk_sys(clk_sys), .ref_on(ref_on), .src_on(src_on),
      .pfd_ref_edge(pfd_e), .pfd_cycle(pfd_c), .lock_level(lvl));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic pcyc(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         while (pfd_c !== 1'h1) @(posedge clk_sys);
      end
   endtask
   task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ck1(input string nm, input logic e, input logic s);
      ck(nm, {7'h0, e}, {7'h0, s});
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wd <= d;
      wr_s <= 1'h1;
      @(posedge clk_sys);
      wr_s <= 1'h0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk_sys);
      rd_s <= 1'h0;
      #1 d = rdata;
   endtask
   // a missing release pulse or a late release both show up here
   task automatic wait_rel(input string nm);
      int b0;
      b0 = nb;
      for (int i = 0; i < 40 && hiz === 1'h1; i++) @(posedge clk_sys);
      cyc(2);
      ck1({nm, " hiz"}, 1'h0, hiz);
      ck({nm, " b reset"}, 8'(b0 + 1), 8'(nb));
   endtask
   task automatic t_regs;
      wr(`REG_HOLDOVER, 8'hFF);
      rd(`REG_HOLDOVER, v);
      ck("holdover reg", 8'h0F, v);
      wr(`REG_HOLDOVER, 8'h00);
      wr(`REG_REF_CTRL, 8'h06);
      cyc(2);
      ck("ref buffers", 8'h03, {6'h0, rbuf});
      rd(10'h010, v);
      ck("unmapped", 8'h00, v);
   endtask
   task automatic t_manual;
      wr(`REG_HOLDOVER, 8'h03);
      align_n <= 1'h0;
      cyc(3);
      ck1("hiz half enabled", 1'h0, hiz);
      align_n <= 1'h1;
      // no channel dividers listen to the align pin in this bench
      wr(`REG_HOLDOVER, 8'h07);
      ref_on <= 1'h0;
      cyc(1);
      align_n <= 1'h0;
      cyc(2);
      ck1("hiz on fall", 1'h1, hiz);
      align_n <= 1'h1;
      cyc(30);
      ck1("hiz no ref", 1'h1, hiz);
      ref_on <= 1'h1;
      wait_rel("manual");
   endtask
   task automatic t_lock;
      wr(`REG_LOCK_DET, 8'h00);
      pcyc(1);
      diff <= 8'h10;
      pcyc(4);
      cyc(3);
      ck1("lock after 4", 1'h0, dlf);
      pcyc(1);
      cyc(3);
      ck1("lock after 5", 1'h1, dlf);
      diff <= 8'h30;
      pcyc(2);
      cyc(3);
      ck1("lock held", 1'h1, dlf);
      diff <= 8'h50;
      pcyc(1);
      cyc(3);
      ck1("lock lost", 1'h0, dlf);
   endtask
   task automatic t_auto;
      wr(`REG_LD_PIN_SEL, 8'h04);
      wr(`REG_HOLDOVER, 8'h08);
      diff <= 8'h10;
      pcyc(6);
      cyc(20);
      ck1("pin charged", 1'h1, lvl);
      wr(`REG_HOLDOVER, 8'h0D);
      cyc(4);
      ck1("hiz while locked", 1'h0, hiz);
      diff <= 8'h50;
      pcyc(1);
      ref_on <= 1'h0;
      cyc(10);
      ck1("hiz on lock loss", 1'h1, hiz);
      ck1("pin shorted", 1'h1, poe);
      cyc(40);
      ck1("hiz without ref", 1'h1, hiz);
      diff <= 8'h10;
      ref_on <= 1'h1;
      wait_rel("auto");
      cyc(25);
      ck1("no reentry", 1'h0, hiz);
      cyc(60);
      wr(`REG_REF_CTRL, 8'h07);
      for (int i = 0; i < 10 && hiz !== 1'h1; i++) @(posedge clk_sys);
      ck1("switchover hiz", 1'h1, hiz);
      ck1("ref select", 1'h1, rsel);
      wait_rel("switchover");
   endtask
   task automatic t_comp_off;
      wr(`REG_HOLDOVER, 8'h05);
      diff <= 8'h50;
      pcyc(2);
      cyc(12);
      ck1("comparator off", 1'h0, hiz);
   endtask
   task automatic t_monitor;
      wr(`REG_REFERENCE_MONITOR_PIN_SEL, 8'hF7);
      cyc(3);
      ck1("reference_monitor_pin slow", 1'h1, reference_monitor_pin);
      rd(`REG_STATUS, v);
      ck("status slow", 8'h07, {5'h0, v[3:1]});
      tick_en <= 1'h1;
      cyc(20);
      ck1("reference_monitor_pin ok", 1'h0, reference_monitor_pin);
      rd(`REG_STATUS, v);
      ck("status ok", 8'h00, {5'h0, v[3:1]});
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(8);
      reset <= 1'h0;
      cyc(1);
      t_regs();
      t_manual();
      t_lock();
      t_auto();
      t_comp_off();
      t_monitor();
      summarize();
   end
   initial begin
      #20000;
      err_total++;
      summarize();
   end
endmodule
bind pll_holdover_controller pll_holdover_controller_chk i_pll_holdover_controller_chk (
   .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .pfd_ref_edge(pfd_ref_edge), .pfd_cycle(pfd_cycle), .align_req_n(align_req_n),
   .charge_pump_hiz_ff(charge_pump_hiz_ff), .b_counter_reset_ff(b_counter_reset_ff),
   .digital_lock_flag_ff(digital_lock_flag_ff));
